/* File: hdl/fp_control_status_defines.vh */
// bit positions, field widths and fixed values of the fp control and status register
`ifndef FP_CONTROL_STATUS_DEFINES_VH
`define FP_CONTROL_STATUS_DEFINES_VH
`define FCS_REG_NUM 5'h1f
`define FCS_COP_NUM 2'h1
`define FCS_CC_HI_MSB 31
`define FCS_CC_HI_LSB 25
`define FCS_FTZ_BIT 24
`define FCS_CC_LO_BIT 23
`define FCS_OVR_BIT 22
`define FCS_NEAR_BIT 21
`define FCS_FMA_BIT 20
`define FCS_ABS_BIT 19
`define FCS_NAN_BIT 18
`define FCS_CAUSE_MSB 17
`define FCS_CAUSE_LSB 12
`define FCS_UNIMP_BIT 17
`define FCS_EN_MSB 11
`define FCS_EN_LSB 7
`define FCS_FLAG_MSB 6
`define FCS_FLAG_LSB 2
`define FCS_RND_MSB 1
`define FCS_RND_LSB 0
`define FCS_FMA_VAL 1'h0
`define FCS_ABS_VAL 1'h1
`define FCS_NAN_VAL 1'h1
`define FCS_CODE_COUNT 8
`define FCS_RST_CODES 8'h00
`define FCS_RST_CTL 1'h0
`define FCS_RST_EN 5'h00
`define FCS_RST_FLAGS 5'h00
`define FCS_RST_CAUSE 6'h00
`define FCS_RST_READ 32'h00000000
`define FCS_RST_TRAP 1'h1
`define RND_NEAREST 2'h0
`define RND_ZERO 2'h1
`define RND_PLUS 2'h2
`define RND_MINUS 2'h3
`define TINY_TRAP 2'h0
`define TINY_FLUSH 2'h1
`define TINY_NEAREST 2'h2
`define TINY_KEEP 2'h3
`endif

/* File: hdl/fp_tiny_policy.v */
// decodes flush controls and rounding mode into denormal and tiny-result handling
`timescale 1ns/1ps
`include "fp_control_status_defines.vh"
module fp_tiny_policy (
	input wire flushToZeroCtl,
	input wire flushOverride,
	input wire flushNearestCtl,
	input wire [1:0] roundSelect,
	output reg [1:0] tinyMode,
	output reg flushToMax,
	output wire denormTrap
);
	// RULE4: trap on denormals
	assign denormTrap = ~flushToZeroCtl;
	always @* begin
		tinyMode = `TINY_TRAP;
		flushToMax = 1'h0;
		// RULE5: override keeps exponent
		if (flushOverride) begin
			tinyMode = `TINY_KEEP;
		// RULE7: nearest flush
		end else if (flushNearestCtl && roundSelect == `RND_NEAREST) begin
			tinyMode = `TINY_NEAREST;
		// RULE6: else flush if flush_to_zero or nearest flush set
		end else if (flushNearestCtl || flushToZeroCtl) begin
			tinyMode = `TINY_FLUSH;
			// RULE3: direction picks smallest normal
			flushToMax = (roundSelect == `RND_PLUS) || (roundSelect == `RND_MINUS);
		end
	end
endmodule

/* File: hdl/fp_control_status_reg.v */
// floating point control and status register, coprocessor 1 register 31
// Overview of operation
// RULE1: 32-bit control/status register reached as coprocessor 1 register 31.
// RULE2: eight compare codes at bit 23 and 31..25, tested by branches and moves.
// RULE3: flush_to_zero set flushes denormal inputs and tiny results by rounding mode.
// RULE4: flush_to_zero clear makes denormal inputs raise unimplemented-operation.
// RULE5: flush_override set keeps tiny intermediates, no forcing, no exception.
// RULE6: override or nearest clear leaves tiny handling to flush_to_zero; the code needs both clear, since nearest set flushes outside nearest mode.
// RULE7: nearest flush picks closer of zero/smallest normal in nearest mode.
// RULE8: bit 20 reads 0; multiply-add is unfused.
// RULE9: bit 19 reads 1; abs and negate pass quiet NaN untrapped.
// RULE10: bit 18 reads 1; quiet NaN has fraction MSB 1.
// RULE11: cause bits 17..12 show last arithmetic exceptions; bit 17 unimplemented.
// RULE12: enables 11..7, flags 6..2, round_select 1..0 writable, power-on undefined.
// RULE13: round_select 0 nearest, 1 zero, 2 plus infinity, 3 minus infinity.
`timescale 1ns/1ps
`include "fp_control_status_defines.vh"
module fp_control_status_reg (
	input wire clk,
	input wire reset,
	input wire cpWrEn,
	input wire [1:0] cpNum,
	input wire [4:0] cpReg,
	input wire [31:0] cpWrData,
	output reg [31:0] cpRdData,
	input wire cmpValid,
	input wire [2:0] cmpIdx,
	input wire cmpResult,
	input wire [2:0] ccSel,
	output reg ccTest,
	input wire arithDone,
	input wire [5:0] arithCause,
	input wire arithDenormIn,
	output reg [7:0] fpCompareCodes,
	output reg flushToZeroCtl,
	output reg flushOverride,
	output reg flushNearestCtl,
	output reg [1:0] roundSelect,
	output reg [4:0] excEnable,
	output reg [4:0] excFlags,
	output reg [5:0] excCause,
	output reg [1:0] tinyMode,
	output reg flushToMax,
	output reg denormTrap
);
	wire sel;
	wire wrHit;
	wire [7:0] cmpHit;
	wire [7:0] writtenCodes;
	wire [7:0] fpCompareCodes_nxt;
	wire [1:0] tinyMode_nxt;
	wire flushToMax_nxt;
	wire denormTrap_nxt;
	reg flushToZeroCtl_nxt;
	reg flushOverride_nxt;
	reg flushNearestCtl_nxt;
	reg [1:0] roundSelect_nxt;
	reg [4:0] excEnable_nxt;
	reg [4:0] excFlags_nxt;
	reg [5:0] excCause_nxt;
	reg [5:0] cause_nxt;
	reg [31:0] regValue;
	reg [31:0] cpRdData_nxt;
	reg ccTest_nxt;
	genvar k;

	// RULE1: decode cop1 reg 31
	assign sel = (cpNum == `FCS_COP_NUM) && (cpReg == `FCS_REG_NUM);
	assign wrHit = cpWrEn && sel;

	// RULE2: one-hot compare target
	assign cmpHit = cmpValid ? (8'h01 << cmpIdx) : 8'h00;
	// RULE2: codes split around bit 24
	assign writtenCodes = {cpWrData[`FCS_CC_HI_MSB:`FCS_CC_HI_LSB],
		cpWrData[`FCS_CC_LO_BIT]};

	// a compare beats a same-cycle write, but only for the code it targets
	generate
		for (k = 0; k < `FCS_CODE_COUNT; k = k + 1) begin : codeSlice
			// RULE2: capture compare outcome
			assign fpCompareCodes_nxt[k] = cmpHit[k] ? cmpResult :
				(wrHit ? writtenCodes[k] : fpCompareCodes[k]);
		end
	endgenerate

	// RULE12: software write of control fields
	always @* begin
		flushToZeroCtl_nxt = flushToZeroCtl;
		flushOverride_nxt = flushOverride;
		flushNearestCtl_nxt = flushNearestCtl;
		excEnable_nxt = excEnable;
		roundSelect_nxt = roundSelect;
		if (wrHit) begin
			flushToZeroCtl_nxt = cpWrData[`FCS_FTZ_BIT];
			flushOverride_nxt = cpWrData[`FCS_OVR_BIT];
			flushNearestCtl_nxt = cpWrData[`FCS_NEAR_BIT];
			excEnable_nxt = cpWrData[`FCS_EN_MSB:`FCS_EN_LSB];
			// RULE13: mode encoding stored as written
			roundSelect_nxt = cpWrData[`FCS_RND_MSB:`FCS_RND_LSB];
		end
	end

	// RULE11: unimplemented bit on denormal trap
	always @* begin
		cause_nxt = arithCause;
		cause_nxt[`FCS_UNIMP_BIT - `FCS_CAUSE_LSB] = arithCause[5] |
			(arithDenormIn & ~flushToZeroCtl);
	end

	// RULE11: cause replaced per instruction; flags only gain bits from it
	always @* begin
		excCause_nxt = excCause;
		excFlags_nxt = excFlags;
		if (wrHit) begin
			excCause_nxt = cpWrData[`FCS_CAUSE_MSB:`FCS_CAUSE_LSB];
			excFlags_nxt = cpWrData[`FCS_FLAG_MSB:`FCS_FLAG_LSB];
		end
		// set beats a clearing write in the same cycle
		if (arithDone) begin
			excCause_nxt = cause_nxt;
			excFlags_nxt = excFlags_nxt | cause_nxt[4:0];
		end
	end

	always @* begin
		regValue = 32'h00000000;
		// RULE2: codes split around bit 24
		regValue[`FCS_CC_HI_MSB:`FCS_CC_HI_LSB] = fpCompareCodes[7:1];
		regValue[`FCS_CC_LO_BIT] = fpCompareCodes[0];
		regValue[`FCS_FTZ_BIT] = flushToZeroCtl;
		regValue[`FCS_OVR_BIT] = flushOverride;
		regValue[`FCS_NEAR_BIT] = flushNearestCtl;
		// RULE8: unfused, reads 0
		regValue[`FCS_FMA_BIT] = `FCS_FMA_VAL;
		// RULE9: abs/neg 2008 style
		regValue[`FCS_ABS_BIT] = `FCS_ABS_VAL;
		// RULE10: 2008 nan encoding
		regValue[`FCS_NAN_BIT] = `FCS_NAN_VAL;
		regValue[`FCS_CAUSE_MSB:`FCS_CAUSE_LSB] = excCause;
		regValue[`FCS_EN_MSB:`FCS_EN_LSB] = excEnable;
		regValue[`FCS_FLAG_MSB:`FCS_FLAG_LSB] = excFlags;
		regValue[`FCS_RND_MSB:`FCS_RND_LSB] = roundSelect;
	end

	// unselected reads give zero so a stray move leaks nothing
	always @* begin
		cpRdData_nxt = `FCS_RST_READ;
		if (sel)
			cpRdData_nxt = regValue;
	end

	// RULE2: branch test of selected code
	always @* begin
		ccTest_nxt = fpCompareCodes[ccSel];
	end

	fp_tiny_policy i_fp_tiny_policy (
		.flushToZeroCtl(flushToZeroCtl),
		.flushOverride(flushOverride),
		.flushNearestCtl(flushNearestCtl),
		.roundSelect(roundSelect),
		.tinyMode(tinyMode_nxt),
		.flushToMax(flushToMax_nxt),
		.denormTrap(denormTrap_nxt)
	);

	// power-on value is undefined; reset clears so simulation is deterministic
	always @(posedge clk) begin
		if (reset) begin
			fpCompareCodes <= `FCS_RST_CODES;
		end else begin
			fpCompareCodes <= fpCompareCodes_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			flushToZeroCtl <= `FCS_RST_CTL;
		end else begin
			flushToZeroCtl <= flushToZeroCtl_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			flushOverride <= `FCS_RST_CTL;
		end else begin
			flushOverride <= flushOverride_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			flushNearestCtl <= `FCS_RST_CTL;
		end else begin
			flushNearestCtl <= flushNearestCtl_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			roundSelect <= `RND_NEAREST;
		end else begin
			roundSelect <= roundSelect_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			excEnable <= `FCS_RST_EN;
		end else begin
			excEnable <= excEnable_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			excFlags <= `FCS_RST_FLAGS;
		end else begin
			excFlags <= excFlags_nxt;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			excCause <= `FCS_RST_CAUSE;
		end else begin
			excCause <= excCause_nxt;
		end
	end

	// read image and branch test are registered, one cycle behind the request
	always @(posedge clk) begin
		if (reset) begin
			cpRdData <= `FCS_RST_READ;
			ccTest <= `FCS_RST_CTL;
		end else begin
			cpRdData <= cpRdData_nxt;
			ccTest <= ccTest_nxt;
		end
	end

	// policy outputs lag the fields by one cycle; registered for clean levels
	always @(posedge clk) begin
		if (reset) begin
			tinyMode <= `TINY_TRAP;
			flushToMax <= `FCS_RST_CTL;
			denormTrap <= `FCS_RST_TRAP;
		end else begin
			tinyMode <= tinyMode_nxt;
			flushToMax <= flushToMax_nxt;
			denormTrap <= denormTrap_nxt;
		end
	end
endmodule

/* File: tb/fp_control_status_reg_asserts.sv */
// port assertions for the fp control and status register
`timescale 1ns/1ps
module fp_control_status_reg_asserts (
	input wire clk, input wire reset, input wire cpWrEn, input wire [1:0] cpNum,
	input wire [4:0] cpReg, input wire [31:0] cpWrData, input wire [31:0] cpRdData,
	input wire cmpValid, input wire [2:0] cmpIdx, input wire cmpResult, input wire [2:0] ccSel,
	input wire ccTest, input wire arithDone, input wire [5:0] arithCause,
	input wire arithDenormIn, input wire [7:0] fpCompareCodes, input wire flushToZeroCtl,
	input wire flushOverride, input wire flushNearestCtl, input wire [1:0] roundSelect,
	input wire [4:0] excEnable, input wire [4:0] excFlags, input wire [5:0] excCause,
	input wire [1:0] tinyMode, input wire flushToMax, input wire denormTrap
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire sel = cpNum == 2'h1 && cpReg == 5'h1f;
	// events merge with writes, so write checks need a quiet cycle
	wire quiet = !cmpValid && !arithDone;
	a_fixed_bits: assert property (sel |=> cpRdData[20:18] == 3'h3)
		else $error("fixed bits wrong");
	a_other_reg: assert property (!sel |=> cpRdData == 32'h0)
		else $error("unselected read not zero");
	a_write_take: assert property (cpWrEn && sel && quiet |=>
		{roundSelect, excEnable} == $past({cpWrData[1:0], cpWrData[11:7]})) else $error("no write");
	a_write_refused: assert property (cpWrEn && !sel && quiet |=>
		$stable({roundSelect, excEnable, excFlags, flushToZeroCtl})) else $error("stray write");
	a_cmp_code: assert property (cmpValid |=>
		fpCompareCodes[$past(cmpIdx)] == $past(cmpResult)) else $error("code not set");
	a_denorm_trap: assert property (1 |=> denormTrap == !$past(flushToZeroCtl))
		else $error("trap enable wrong");
	a_override_keep: assert property (flushOverride |=> tinyMode == 2'h3)
		else $error("override ignored");
	a_unimp_cause: assert property (arithDone && arithDenormIn && !flushToZeroCtl && !cpWrEn |=>
		excCause[5]) else $error("unimplemented cause missing");
	a_flags_sticky: assert property (arithDone && !cpWrEn |=>
		(excFlags & $past(arithCause[4:0])) == $past(arithCause[4:0])) else $error("flag lost");
	a_nearest_flush: assert property (flushNearestCtl && !flushOverride && roundSelect == 2'h0 |=>
		tinyMode == 2'h2) else $error("nearest flush not chosen");
	a_flush_dir: assert property (flushToZeroCtl && !flushOverride && !flushNearestCtl |=>
		tinyMode == 2'h1 && flushToMax == $past(roundSelect[1])) else $error("flush choice wrong");
	a_trap_mode: assert property (!flushToZeroCtl && !flushOverride && !flushNearestCtl |=>
		tinyMode == 2'h0) else $error("tiny trap not chosen");
	a_cc_test: assert property (1 |=> ccTest == $past(fpCompareCodes[ccSel]))
		else $error("branch test wrong");
endmodule
bind fp_control_status_reg fp_control_status_reg_asserts i_fp_control_status_reg_asserts (
	.clk(clk), .reset(reset), .cpWrEn(cpWrEn), .cpNum(cpNum), .cpReg(cpReg),
	.cpWrData(cpWrData), .cpRdData(cpRdData), .cmpValid(cmpValid), .cmpIdx(cmpIdx),
	.cmpResult(cmpResult), .ccSel(ccSel), .ccTest(ccTest), .arithDone(arithDone),
	.arithCause(arithCause), .arithDenormIn(arithDenormIn), .fpCompareCodes(fpCompareCodes),
	.flushToZeroCtl(flushToZeroCtl), .flushOverride(flushOverride),
	.flushNearestCtl(flushNearestCtl), .roundSelect(roundSelect), .excEnable(excEnable),
	.excFlags(excFlags), .excCause(excCause), .tinyMode(tinyMode), .flushToMax(flushToMax),
	.denormTrap(denormTrap)
);

/* File: tb/fp_pipeline_model.sv */
// core pipeline model: coprocessor moves, compares, arithmetic retirements
`timescale 1ns/1ps
module fp_pipeline_model (
	input wire clk,
	output reg cpWrEn = 0, output reg [1:0] cpNum = 1, output reg [4:0] cpReg = 31,
	output reg [31:0] cpWrData = 0, output reg cmpValid = 0, output reg [2:0] cmpIdx = 0,
	output reg cmpResult = 0, output reg arithDone = 0, output reg [5:0] arithCause = 0,
	output reg arithDenormIn = 0
);
	// extra cycle so the read image already holds the new value
	task wr(input [1:0] n, input [4:0] r, input [31:0] d);
		@(negedge clk) {cpWrEn, cpNum, cpReg, cpWrData} = {1'b1, n, r, d};
		@(negedge clk) {cpWrEn, cpNum, cpReg, cpWrData} = {1'b0, 2'h1, 5'h1f, ~d};
		@(negedge clk);
	endtask
	task ev(input [2:0] i, input c, input a, input [5:0] k, input dn);
		@(negedge clk) {cmpValid, cmpIdx, cmpResult, arithDone, arithCause, arithDenormIn} =
			{!a, i, c, a, k, dn};
		@(negedge clk) {cmpValid, cmpResult, arithDone, arithCause} = {1'b0, !c, 1'b0, ~k};
		@(negedge clk);
	endtask
endmodule

/* File: tb/test_fp_control_status_reg.sv */
// self-checking bench for the fp control and status register
`timescale 1ns/1ps
module test_fp_control_status_reg;
	reg clk = 0;
	reg reset = 1;
	reg [2:0] ccSel = 0;
	wire cpWrEn, cmpValid, cmpResult, arithDone, arithDenormIn, ccTest, flushToZeroCtl;
	wire flushOverride, flushNearestCtl, flushToMax, denormTrap;
	wire [1:0] cpNum, roundSelect, tinyMode;
	wire [4:0] cpReg, excEnable, excFlags;
	wire [31:0] cpWrData, cpRdData;
	wire [2:0] cmpIdx;
	wire [5:0] arithCause, excCause;
	wire [7:0] fpCompareCodes;
	integer failures = 0, samples_checked = 0, cycles = 0, i;
	fp_control_status_reg i_fp_control_status_reg (
		.clk(clk), .reset(reset), .cpWrEn(cpWrEn), .cpNum(cpNum), .cpReg(cpReg),
		.cpWrData(cpWrData), .cpRdData(cpRdData), .cmpValid(cmpValid), .cmpIdx(cmpIdx),
		.cmpResult(cmpResult), .ccSel(ccSel), .ccTest(ccTest), .arithDone(arithDone),
		.arithCause(arithCause), .arithDenormIn(arithDenormIn), .fpCompareCodes(fpCompareCodes),
		.flushToZeroCtl(flushToZeroCtl), .flushOverride(flushOverride),
		.flushNearestCtl(flushNearestCtl), .roundSelect(roundSelect), .excEnable(excEnable),
		.excFlags(excFlags), .excCause(excCause), .tinyMode(tinyMode), .flushToMax(flushToMax),
		.denormTrap(denormTrap)
	);
	fp_pipeline_model i_fp_pipeline_model (
		.clk(clk), .cpWrEn(cpWrEn), .cpNum(cpNum), .cpReg(cpReg), .cpWrData(cpWrData),
		.cmpValid(cmpValid), .cmpIdx(cmpIdx), .cmpResult(cmpResult), .arithDone(arithDone),
		.arithCause(arithCause), .arithDenormIn(arithDenormIn)
	);
	initial forever #10 clk = ~clk;
	task summarize;
		$display("checked %0d, wrong %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task mode(input [31:0] d, input [1:0] t);
		i_fp_pipeline_model.wr(2'h1, 5'h1f, d);
		chk(tinyMode, t);
	endtask
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 1000) begin
			failures = failures + 1;
			summarize;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk) reset = 0;
		@(negedge clk);
		chk(cpRdData, 32'h000c0000);
		chk(denormTrap, 1);
		i_fp_pipeline_model.wr(2'h1, 5'h1f, 32'hffffffff);
		chk(cpRdData, 32'hffefffff);
		chk({fpCompareCodes, flushNearestCtl, excEnable}, {8'hff, 1'b1, 5'h1f});
		i_fp_pipeline_model.wr(2'h1, 5'h1e, 32'h0);
		chk(cpRdData, 32'hffefffff);
		i_fp_pipeline_model.wr(2'h2, 5'h1f, 32'h0);
		chk(cpRdData, 32'hffefffff);
		$display("access test done");
		for (i = 0; i < 4; i = i + 1) begin
			mode(32'h01000000 | i, 1);
			chk(flushToMax, i > 1);
		end
		mode(32'h00200000, 2);
		mode(32'h00200001, 1);
		mode(32'h00400000, 3);
		mode(32'h0, 0);
		$display("tiny test done");
		for (i = 0; i < 8; i = i + 1) i_fp_pipeline_model.ev(i, i[0], 0, 0, 0);
		ccSel = 3;
		@(negedge clk);
		chk(cpRdData, 32'haa0c0000);
		chk(ccTest, 1);
		i_fp_pipeline_model.ev(0, 0, 1, 6'h01, 1);
		chk({excCause, excFlags}, {6'h21, 5'h01});
		i_fp_pipeline_model.ev(0, 0, 1, 6'h02, 0);
		chk({excCause, excFlags}, {6'h02, 5'h03});
		$display("event test done");
		summarize;
	end
endmodule
